// >>> core/pcg_pkg.sv
// package of the clock generator control block: register map, field positions, reset values
// assumes an 8-bit register port with one-cycle strobes
package pcg_pkg;

    // ==========================================================
    // register map
    localparam logic [0:0] ADDR_CTRL = 1'h0;
    localparam logic [0:0] ADDR_BW = 1'h1;

    // ==========================================================
    // control register fields
    localparam int CTRL_IE_BIT = 7;
    localparam int CTRL_FLAG_BIT = 6;
    localparam int CTRL_PWR_BIT = 5;
    localparam int CTRL_SEL_BIT = 4;
    localparam logic [3:0] CTRL_UNUSED_VAL = 4'hf;

    // ==========================================================
    // bandwidth register fields
    localparam int BW_AUTO_BIT = 7;
    localparam int BW_SETTLED_BIT = 6;
    localparam int BW_TRACK_BIT = 5;
    localparam int BW_LOSS_BIT = 4;
    localparam logic [3:0] BW_TEST_VAL = 4'h0;

    // ==========================================================
    // reset values
    localparam logic RST_IE = 1'b0;
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_PWR = 1'b1;
    localparam logic RST_SEL = 1'b0;
    localparam logic RST_AUTO = 1'b0;
    localparam logic RST_TRACK = 1'b0;

    // ==========================================================
    // switchover timing: source edges held static on each side
    localparam logic [1:0] XFER_EDGES = 2'h3;

    typedef enum logic [1:0] {
        PCG_RUN,
        PCG_HOLD_OLD,
        PCG_HOLD_NEW
    } pcg_sw_e;

endpackage

// >>> core/pcg_ctrl.sv
// clock generator control: source select, base clock halving, settle flag, bandwidth mode
// assumes crystal, vco, lock and tracking inputs are asynchronous and are sampled here
//
// Function
// (R1) base clock is 50% duty, selected source halved
// (R2) interrupt output comes from the lock detector change flag
// (R3) oscillator and pll run only while oscillator enable is high
// (R4) settle irq enable ignores writes, reads 0 without auto; reset clears
// (R5) settle change flag sets on each settled change; irq when flag and enable
// (R6) settle change flag reads 0 while auto bandwidth is 0
// (R7) any read of control register clears settle change flag
// (R8) pll power set by reset; clearing ignored while source select is 1
// (R9) setting source select ignored while pll power is clear
// (R10) software powers pll, then sets source select in a second write
// (R11) base clock held static up to three old, three new source edges
// (R12) source select cleared by reset and by stop
// (R13) select 1 uses vco clock halved, 0 crystal clock halved
// (R14) control bits 3..0 ignore writes and read as ones
// (R15) auto bandwidth bit read/write, reset clear, 1 auto, 0 manual
// (R16) software clears filter mode before powering pll in manual mode
// (R17) settled indicator shows lock in auto mode, 0 in manual, reset 0
// (R18) filter mode read-only status in auto, writable in manual, reset 0
// (R19) manual filter mode kept hidden during auto and restored after
// (R20) write 1 to loss bit, wait, read: 1 means crystal inactive
// (R21) loss detection only while source select 1, else reads 0
// (R22) software writes zeros to bandwidth test bits
// (R23) zero range multiplier disables pll and forces crystal source
// (R24) select change crosses into each source domain without runt pulses
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module pcg_ctrl #(
    parameter int ADDR_W = 1
)
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rd_data,
    input wire logic i_crystal_clock,
    input wire logic i_vco_clock,
    input wire logic i_lock_det,
    input wire logic i_track_det,
    input wire logic i_osc_enable_in,
    input wire logic i_stop,
    input wire logic i_range_zero,
    output logic o_base_clock_out,
    output logic o_gen_irq_out,
    output logic o_osc_run,
    output logic o_pll_run,
    output logic o_auto_bw,
    output logic o_filter_track,
    output logic o_vco_active
);

    // ==========================================================
    // elaboration check
    // the register index needs at least one bit to reach both registers
    if (ADDR_W < 1)
    begin : g_bad_addr_w
        $error("pcg_ctrl: ADDR_W must be at least 1");
    end

    // ==========================================================
    // state
    typedef struct packed {
        logic [1:0] xclk_sy;
        logic [1:0] vclk_sy;
        logic [1:0] lock_sy;
        logic [1:0] trk_sy;
        logic xclk_prev;
        logic vclk_prev;
        logic settled_prev;
        logic ie;
        logic flag;
        logic pwr;
        logic sel;
        logic auto_bw;
        logic track_man;
        logic loss;
        logic vco_act;
        pcg_pkg::pcg_sw_e sw;
        logic [1:0] cnt;
        logic base;
        logic [7:0] rdata;
    } pcg_state_s;

    pcg_state_s st_q;
    pcg_state_s st_d;

    logic x_rise;
    logic v_rise;
    logic old_rise;
    logic new_rise;
    logic settled;
    logic ctrl_hit;
    logic bw_hit;
    logic pll_ok;

    always_comb
    begin
        x_rise = st_q.xclk_sy[1] & ~st_q.xclk_prev;
        v_rise = st_q.vclk_sy[1] & ~st_q.vclk_prev;
        old_rise = st_q.vco_act ? v_rise : x_rise;
        new_rise = st_q.vco_act ? x_rise : v_rise;
        settled = st_q.auto_bw & st_q.lock_sy[1]; // (R17)
        ctrl_hit = (i_addr == ADDR_W'(pcg_pkg::ADDR_CTRL));
        bw_hit = (i_addr == ADDR_W'(pcg_pkg::ADDR_BW));
        pll_ok = i_osc_enable_in & ~i_range_zero; // (R3) (R23)

        st_d = st_q;
        // first stage feeds only the second stage
        st_d.xclk_sy = {st_q.xclk_sy[0], i_crystal_clock};
        st_d.vclk_sy = {st_q.vclk_sy[0], i_vco_clock};
        st_d.lock_sy = {st_q.lock_sy[0], i_lock_det};
        st_d.trk_sy = {st_q.trk_sy[0], i_track_det};
        st_d.xclk_prev = st_q.xclk_sy[1];
        st_d.vclk_prev = st_q.vclk_sy[1];
        st_d.settled_prev = settled;

        // ======================================================
        // register writes
        if (i_wr && ctrl_hit)
        begin
            if (st_q.auto_bw)
            begin
                st_d.ie = i_wr_data[pcg_pkg::CTRL_IE_BIT]; // (R4)
            end
            if (i_wr_data[pcg_pkg::CTRL_PWR_BIT] || !st_q.sel)
            begin
                st_d.pwr = i_wr_data[pcg_pkg::CTRL_PWR_BIT]; // (R8)
            end
            // old power value gates the set, so one write cannot do both
            if (!i_wr_data[pcg_pkg::CTRL_SEL_BIT] || (st_q.pwr && !i_range_zero))
            begin
                st_d.sel = i_wr_data[pcg_pkg::CTRL_SEL_BIT]; // (R9) (R10)
            end
        end
        else if (i_wr && bw_hit)
        begin
            st_d.auto_bw = i_wr_data[pcg_pkg::BW_AUTO_BIT]; // (R15)
            if (!st_q.auto_bw)
            begin
                st_d.track_man = i_wr_data[pcg_pkg::BW_TRACK_BIT]; // (R18) (R19)
            end
            if (i_wr_data[pcg_pkg::BW_LOSS_BIT])
            begin
                st_d.loss = 1'b1; // (R20)
            end
        end

        // crystal edge proves the reference alive
        if (x_rise && !(i_wr && bw_hit && i_wr_data[pcg_pkg::BW_LOSS_BIT]))
        begin
            st_d.loss = 1'b0; // (R20)
        end

        if (i_stop || i_range_zero)
        begin
            st_d.sel = 1'b0; // (R12) (R23)
        end

        // ======================================================
        // settle change flag: read clears, a new change wins
        if (i_rd && ctrl_hit)
        begin
            st_d.flag = 1'b0; // (R7)
        end
        if (settled != st_q.settled_prev)
        begin
            st_d.flag = 1'b1; // (R5)
        end

        // ======================================================
        // read data, one cycle after the strobe
        if (i_rd && ctrl_hit)
        begin
            st_d.rdata = {st_q.ie & st_q.auto_bw, st_q.flag & st_q.auto_bw, // (R4) (R6)
                st_q.pwr, st_q.sel, pcg_pkg::CTRL_UNUSED_VAL}; // (R14)
        end
        else if (i_rd && bw_hit)
        begin
            st_d.rdata = {st_q.auto_bw, settled,
                st_q.auto_bw ? st_q.trk_sy[1] : st_q.track_man, // (R18)
                st_q.loss & st_q.sel, pcg_pkg::BW_TEST_VAL}; // (R21)
        end
        else if (i_rd)
        begin
            st_d.rdata = 8'h00;
        end

        // ======================================================
        // glitch-free switchover; output only changes from this flop
        case (st_q.sw)
            pcg_pkg::PCG_RUN:
            begin
                if (old_rise)
                begin
                    st_d.base = ~st_q.base; // (R1) (R13)
                end
                if (st_q.sel != st_q.vco_act)
                begin
                    st_d.sw = pcg_pkg::PCG_HOLD_OLD;
                    st_d.cnt = 2'h0;
                end
            end
            pcg_pkg::PCG_HOLD_OLD:
            begin
                if (old_rise)
                begin
                    st_d.cnt = st_q.cnt + 2'h1;
                end
                if (old_rise && st_q.cnt == pcg_pkg::XFER_EDGES - 2'h1)
                begin
                    st_d.sw = pcg_pkg::PCG_HOLD_NEW; // (R11) (R24)
                    st_d.cnt = 2'h0;
                    st_d.vco_act = ~st_q.vco_act;
                end
            end
            pcg_pkg::PCG_HOLD_NEW:
            begin
                // vco_act already flipped, so old_rise is the new source here
                if (old_rise)
                begin
                    st_d.cnt = st_q.cnt + 2'h1;
                end
                if (old_rise && st_q.cnt == pcg_pkg::XFER_EDGES - 2'h1)
                begin
                    st_d.sw = pcg_pkg::PCG_RUN; // (R11)
                end
            end
            default:
            begin
                st_d.sw = pcg_pkg::PCG_RUN;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_q <= '0;
            st_q.ie <= pcg_pkg::RST_IE; // (R4)
            st_q.flag <= pcg_pkg::RST_FLAG; // (R5)
            st_q.pwr <= pcg_pkg::RST_PWR; // (R8)
            st_q.sel <= pcg_pkg::RST_SEL; // (R12)
            st_q.auto_bw <= pcg_pkg::RST_AUTO; // (R15)
            st_q.track_man <= pcg_pkg::RST_TRACK; // (R18)
            st_q.sw <= pcg_pkg::PCG_RUN;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // outputs
    assign o_rd_data = st_q.rdata;
    assign o_base_clock_out = st_q.base;
    assign o_gen_irq_out = st_q.flag & st_q.ie & st_q.auto_bw; // (R2) (R5)
    assign o_osc_run = i_osc_enable_in; // (R3)
    assign o_pll_run = st_q.pwr & pll_ok; // (R3) (R23)
    assign o_auto_bw = st_q.auto_bw;
    assign o_filter_track = st_q.track_man;
    assign o_vco_active = st_q.vco_act;

    // limitation: a dead outgoing source stalls the switchover in the hold state
    // (power cannot clear while vco is selected, but a low oscillator enable still stops the pll and vco then)

endmodule

`default_nettype wire

// >>> sim/pcg_ctrl_monitor.sv
// checker of the clock generator control block, watching its ports only
// assumes the register port protocol of the package and a single mclk domain
`timescale 1ns/1ps
`default_nettype none
module pcg_ctrl_monitor #(
    parameter int ADDR_W = 1
)
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_rd,
    input wire logic [7:0] o_rd_data,
    input wire logic i_osc_enable_in,
    input wire logic i_range_zero,
    input wire logic o_base_clock_out,
    input wire logic o_gen_irq_out,
    input wire logic o_osc_run,
    input wire logic o_pll_run,
    input wire logic o_auto_bw,
    input wire logic o_filter_track,
    input wire logic o_vco_active
);
    // ==========================================================
    // read sequences
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    sequence rd_ctrl;
        i_rd && i_addr == pcg_pkg::ADDR_CTRL;
    endsequence
    sequence rd_bw;
        i_rd && i_addr == pcg_pkg::ADDR_BW;
    endsequence
    osc_follow_a: assert property (o_osc_run == i_osc_enable_in)
        else $error("osc run differs from enable");
    pll_gate_a: assert property (o_pll_run |-> i_osc_enable_in && !i_range_zero)
        else $error("pll runs while blocked");
    irq_auto_a: assert property (o_gen_irq_out |-> o_auto_bw)
        else $error("irq raised in manual mode");
    ctrl_ones_a: assert property (rd_ctrl |=> o_rd_data[3:0] == 4'hf)
        else $error("control low bits not ones");
    manual_flag_a: assert property (rd_ctrl and !o_auto_bw |=> o_rd_data[7:6] == 2'h0)
        else $error("flag or enable read in manual");
    manual_lock_a: assert property (rd_bw and !o_auto_bw |=> !o_rd_data[6])
        else $error("settled read in manual");
    manual_track_a: assert property (rd_bw and !o_auto_bw |=> o_rd_data[5] == $past(o_filter_track))
        else $error("manual track readback wrong");
    auto_read_a: assert property (rd_bw |=> o_rd_data[7] == $past(o_auto_bw))
        else $error("auto bit readback wrong");
    switch_hold_a: assert property ($changed(o_vco_active) |-> $stable(o_base_clock_out))
        else $error("base clock moved at source flip");
endmodule
bind pcg_ctrl pcg_ctrl_monitor #(.ADDR_W(ADDR_W)) u_mon (.i_mclk, .i_rst_b, .i_addr, .i_rd,
    .o_rd_data, .i_osc_enable_in, .i_range_zero, .o_base_clock_out, .o_gen_irq_out,
    .o_osc_run, .o_pll_run, .o_auto_bw, .o_filter_track, .o_vco_active);
`default_nettype wire

// >>> sim/pcg_far_model.sv
// model of the crystal and the pll loop at the block's far side
// assumes lock and tracking levels are commanded by the bench
`timescale 1ns/1ps
`default_nettype none
module pcg_far_model (
    input wire logic i_xtal_ok,
    input wire logic i_pll_run,
    input wire logic i_lock,
    input wire logic i_track,
    output logic o_crystal_clock,
    output logic o_vco_clock,
    output logic o_lock_det,
    output logic o_track_det
);
    // ==========================================================
    // clocks, unrelated to mclk
    initial
    begin
        o_crystal_clock = 1'b0;
        o_vco_clock = 1'b0;
    end
    // a lost crystal stops low; vco only runs while the loop is powered
    always #25 o_crystal_clock = i_xtal_ok ? ~o_crystal_clock : 1'b0;
    always #15 o_vco_clock = i_pll_run ? ~o_vco_clock : 1'b0;
    assign o_lock_det = i_lock & i_pll_run;
    assign o_track_det = i_track & i_pll_run;
endmodule
`default_nettype wire

// >>> sim/pcg_ctrl_tb.sv
// testbench of the clock generator control block: register sequences with expected values
// assumes the far model supplies crystal, vco, lock and tracking levels
`timescale 1ns/1ps
`default_nettype none
module pcg_ctrl_tb;
    logic i_mclk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_stop = 1'b0;
    logic i_osc_enable_in = 1'b1, i_range_zero = 1'b0, xtal_ok = 1'b1, lock = 1'b0, track = 1'b0;
    logic [0:0] i_addr = 1'h0;
    logic [7:0] i_wr_data = 8'h00;
    logic [7:0] o_rd_data;
    logic xc, vc, ld, td, base, irq, osc_run, pll_run, auto_bw, ftrack, vco_act;
    int bad_count = 0, total_checks = 0;
    pcg_far_model far (.i_xtal_ok(xtal_ok), .i_pll_run(pll_run), .i_lock(lock), .i_track(track),
        .o_crystal_clock(xc), .o_vco_clock(vc), .o_lock_det(ld), .o_track_det(td));
    pcg_ctrl #(.ADDR_W(1)) uut (.i_mclk, .i_rst_b, .i_addr, .i_wr_data, .i_wr, .i_rd,
        .o_rd_data, .i_crystal_clock(xc), .i_vco_clock(vc), .i_lock_det(ld), .i_track_det(td),
        .i_osc_enable_in, .i_stop, .i_range_zero, .o_base_clock_out(base), .o_gen_irq_out(irq),
        .o_osc_run(osc_run), .o_pll_run(pll_run), .o_auto_bw(auto_bw),
        .o_filter_track(ftrack), .o_vco_active(vco_act));
    initial
    begin
        forever #2.5 i_mclk = ~i_mclk;
    end
    // ==========================================================
    // tasks
    task automatic finish_test();
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [0:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wr_data <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    // read data appear in the cycle after the strobe and hold until the next read
    task automatic rd(input logic [0:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk(a ? "bandwidth" : "control", e, o_rd_data);
    endtask
    // counts base clock changes over a window; source halved gives one change per source rise
    task automatic base_rate(input int cycles, input int e);
        int n;
        int t;
        logic p;
        t = 0;
        p = base;
        for (n = 0; n < cycles; n++)
        begin
            @(posedge i_mclk);
            if (base !== p)
                t++;
            p = base;
        end
        chk("base_toggles", 8'(e), (t >= e - 1 && t <= e + 1) ? 8'(e) : 8'(t));
    endtask
    task automatic wait_active(input logic v);
        int n;
        for (n = 0; n < 300 && vco_act !== v; n++)
            @(posedge i_mclk);
        chk("vco_active", {7'h0, v}, {7'h0, vco_act});
        if (vco_act !== v)
            finish_test();
    endtask
    // ==========================================================
    // sequence
    initial
    begin
        repeat (10) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        rd(1'h0, 8'h2f);
        rd(1'h1, 8'h00);
        wr(1'h0, 8'ha0);
        rd(1'h0, 8'h2f);
        wr(1'h0, 8'h00);
        rd(1'h0, 8'h0f);
        wr(1'h0, 8'h10);
        rd(1'h0, 8'h0f);
        wr(1'h0, 8'h20);
        wr(1'h0, 8'h30);
        wr(1'h0, 8'h10);
        rd(1'h0, 8'h3f);
        wait_active(1'b1);
        wr(1'h1, 8'h10);
        repeat (40) @(posedge i_mclk);
        base_rate(60, 10);
        rd(1'h1, 8'h00);
        xtal_ok <= 1'b0;
        wr(1'h1, 8'h10);
        repeat (40) @(posedge i_mclk);
        rd(1'h1, 8'h10);
        xtal_ok <= 1'b1;
        i_stop <= 1'b1;
        @(posedge i_mclk);
        i_stop <= 1'b0;
        rd(1'h0, 8'h2f);
        wait_active(1'b0);
        repeat (40) @(posedge i_mclk);
        base_rate(100, 10);
        wr(1'h1, 8'h10);
        rd(1'h1, 8'h00);
        wr(1'h1, 8'h20);
        rd(1'h1, 8'h20);
        chk("filter_track", 8'h01, {7'h0, ftrack});
        wr(1'h1, 8'ha0);
        rd(1'h1, 8'h80);
        track <= 1'b1;
        repeat (10) @(posedge i_mclk);
        rd(1'h1, 8'ha0);
        wr(1'h0, 8'ha0);
        rd(1'h0, 8'haf);
        lock <= 1'b1;
        repeat (10) @(posedge i_mclk);
        chk("irq", 8'h01, {7'h0, irq});
        rd(1'h0, 8'hef);
        chk("irq", 8'h00, {7'h0, irq});
        rd(1'h1, 8'he0);
        wr(1'h1, 8'h00);
        rd(1'h1, 8'h20);
        rd(1'h0, 8'h2f);
        i_range_zero <= 1'b1;
        wr(1'h0, 8'h30);
        rd(1'h0, 8'h2f);
        chk("pll_run", 8'h00, {7'h0, pll_run});
        i_osc_enable_in <= 1'b0;
        @(posedge i_mclk);
        #1 chk("osc_run", 8'h00, {7'h0, osc_run});
        finish_test();
    end
endmodule
`default_nettype wire
